// ---- tcv_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - live count reads as 16-bit current counter value, upper bits zero
// RULE_02 - registers a and b writable only in waveform mode, read-only in capture
// RULE_03 - register a holds 16 bits and reads back its present content
// RULE_04 - register b holds 16 bits and reads back its present content
// RULE_05 - register c is 16-bit read/write in all modes, resets to zero
// RULE_06 - status bit 18 output b mirror, 17 output a mirror, 16 clock enabled
// RULE_07 - status low byte: trigger, b load, a load, c/b/a compare, overrun, overflow
// RULE_08 - reading status clears its event flags and matching pending interrupt bits
// RULE_09 - overrun sets when a or b loads twice unread in capture mode
// RULE_10 - a/b compare flags only in waveform, load flags only in capture mode
// RULE_11 - mirrors show sensed pin in capture, driven level in waveform
// RULE_12 - writes to read-only status or capture registers in capture change nothing
module tcv_top
	import tcv_pkg::*;
(
	input wire logic ref_clk, // system clock, 50 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state
	input wire logic [TCV_AW-1:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	output logic irq, // level interrupt
	input wire logic [TCV_NCH-1:0] wave, // per channel waveform mode
	input wire logic [TCV_NCH-1:0] clk_on, // per channel clock enabled
	input wire logic [TCV_NCH*16-1:0] live_count, // counter values
	input wire logic [TCV_NCH*16-1:0] cap_val, // capture values
	input wire logic [TCV_NCH-1:0] ev_ovf, // overflow pulses
	input wire logic [TCV_NCH-1:0] ev_cmp_a, // a compare pulses
	input wire logic [TCV_NCH-1:0] ev_cmp_b, // b compare pulses
	input wire logic [TCV_NCH-1:0] ev_cmp_c, // c compare pulses
	input wire logic [TCV_NCH-1:0] ev_ld_a, // a load pulses
	input wire logic [TCV_NCH-1:0] ev_ld_b, // b load pulses
	input wire logic [TCV_NCH-1:0] ev_trig, // external trigger pulses
	input wire logic [TCV_NCH-1:0] channel_io_a, // io a pin levels
	input wire logic [TCV_NCH-1:0] channel_io_b, // io b pin levels
	input wire logic [TCV_NCH-1:0] drive_a, // io a driven levels
	input wire logic [TCV_NCH-1:0] drive_b, // io b driven levels
	output logic [TCV_NCH*16-1:0] reg_a_out, // register a to engine
	output logic [TCV_NCH*16-1:0] reg_b_out, // register b to engine
	output logic [TCV_NCH*16-1:0] reg_c_out // register c to engine
);

	// true when addr hits offset ofs of channel ch
	function automatic logic chan_hit(
		input logic [TCV_AW-1:0] a,
		input int ch,
		input logic [5:0] ofs
	);
		logic [TCV_AW-1:0] base;
		base = TCV_AW'(ch) * TCV_CH_STRIDE;
		chan_hit = (a == (base | {2'b00, ofs}));
	endfunction

	// pin synchronisers, two stages each; only stage two is read
	logic [TCV_NCH-1:0] io_a_s1;
	logic [TCV_NCH-1:0] io_a_s2;
	logic [TCV_NCH-1:0] io_b_s1;
	logic [TCV_NCH-1:0] io_b_s2;
	logic [TCV_NCH-1:0] next_io_a_s1;
	logic [TCV_NCH-1:0] next_io_a_s2;
	logic [TCV_NCH-1:0] next_io_b_s1;
	logic [TCV_NCH-1:0] next_io_b_s2;

	// channel register views
	logic [15:0] ra [TCV_NCH];
	logic [15:0] rb [TCV_NCH];
	logic [15:0] rc [TCV_NCH];
	logic [TCV_NFLAG-1:0] flg [TCV_NCH];
	logic [TCV_NFLAG-1:0] evs [TCV_NCH];
	logic [31:0] status_word [TCV_NCH];
	logic [TCV_NCH-1:0] rd_sr;

	// interrupt and bus state
	logic [23:0] irq_pend;
	logic [23:0] irq_mask;
	logic [23:0] next_pend;
	logic [23:0] next_mask;
	logic [23:0] pend_set;
	logic [23:0] pend_rd_clr;
	logic next_irq;
	logic [31:0] next_rdata;

	// synchroniser next values: stage two sees only stage one
	always_comb begin
		next_io_a_s1 = channel_io_a;
		next_io_b_s1 = channel_io_b;
		next_io_a_s2 = io_a_s1;
		next_io_b_s2 = io_b_s1;
	end

	// synchroniser registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			io_a_s1 <= '0;
			io_a_s2 <= '0;
			io_b_s1 <= '0;
			io_b_s2 <= '0;
		end else if (ce) begin
			io_a_s1 <= next_io_a_s1;
			io_a_s2 <= next_io_a_s2;
			io_b_s1 <= next_io_b_s1;
			io_b_s2 <= next_io_b_s2;
		end
	end

	// one register set per channel, repeated at the channel stride
	for (genvar g = 0; g < TCV_NCH; g++) begin : g_ch
		logic mir_a;
		logic mir_b;

		// mirror picks the pin in capture mode, the drive in waveform
		assign mir_a = wave[g] ? drive_a[g] : io_a_s2[g]; // [RULE_11]
		assign mir_b = wave[g] ? drive_b[g] : io_b_s2[g]; // [RULE_11]

		assign rd_sr[g] = rd & chan_hit(addr, g, OFS_STATUS); // [RULE_08]

		tcv_chan u_chan (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.ce(ce),
			.wave(wave[g]),
			.wr_a(wr & chan_hit(addr, g, OFS_CAP_A)),
			.wr_b(wr & chan_hit(addr, g, OFS_CAP_B)),
			.wr_c(wr & chan_hit(addr, g, OFS_CMP_C)),
			.rd_a(rd & chan_hit(addr, g, OFS_CAP_A)),
			.rd_b(rd & chan_hit(addr, g, OFS_CAP_B)),
			.rd_sr(rd_sr[g]),
			.wdata(wdata[15:0]),
			.cap_val(cap_val[g*16 +: 16]),
			.ev_ovf(ev_ovf[g]),
			.ev_cmp_a(ev_cmp_a[g]),
			.ev_cmp_b(ev_cmp_b[g]),
			.ev_cmp_c(ev_cmp_c[g]),
			.ev_ld_a(ev_ld_a[g]),
			.ev_ld_b(ev_ld_b[g]),
			.ev_trig(ev_trig[g]),
			.capture_reg_a(ra[g]),
			.capture_reg_b(rb[g]),
			.period_compare_reg_c(rc[g]),
			.flags(flg[g]),
			.ev_set(evs[g])
		);

		// status word layout; bits not listed read zero
		always_comb begin
			status_word[g] = '0;
			status_word[g][SB_OUT_B_MIR] = mir_b; // [RULE_06]
			status_word[g][SB_OUT_A_MIR] = mir_a; // [RULE_06]
			status_word[g][SB_CLK_EN] = clk_on[g]; // [RULE_06]
			status_word[g][TCV_NFLAG-1:0] = flg[g]; // [RULE_07]
		end

		// flop outputs of the sub-block feed the engine directly
		assign reg_a_out[g*16 +: 16] = ra[g];
		assign reg_b_out[g*16 +: 16] = rb[g];
		assign reg_c_out[g*16 +: 16] = rc[g];

		// pending bits follow the flags; a status read clears its slice
		assign pend_set[g*TCV_NFLAG +: TCV_NFLAG] = evs[g];
		assign pend_rd_clr[g*TCV_NFLAG +: TCV_NFLAG] = {TCV_NFLAG{rd_sr[g]}}; // [RULE_08]
	end

	// read mux; unmapped addresses and cycles without rd answer zero
	always_comb begin
		next_rdata = RST_RDATA;
		if (rd) begin
			for (int c = 0; c < TCV_NCH; c++) begin
				if (chan_hit(addr, c, OFS_LIVE)) begin
					next_rdata = {16'h0000, live_count[c*16 +: 16]}; // [RULE_01]
				end
				if (chan_hit(addr, c, OFS_CAP_A)) begin
					next_rdata = {16'h0000, ra[c]}; // [RULE_03]
				end
				if (chan_hit(addr, c, OFS_CAP_B)) begin
					next_rdata = {16'h0000, rb[c]}; // [RULE_04]
				end
				if (chan_hit(addr, c, OFS_CMP_C)) begin
					next_rdata = {16'h0000, rc[c]}; // [RULE_05]
				end
				if (chan_hit(addr, c, OFS_STATUS)) begin
					next_rdata = status_word[c]; // [RULE_07]
				end
			end
			if (addr == ADDR_IRQ_PEND) begin
				next_rdata = {8'h00, irq_pend};
			end
			if (addr == ADDR_IRQ_MASK) begin
				next_rdata = {8'h00, irq_mask};
			end
		end
	end

	// interrupt pending/mask; a new event wins over any clear
	// status writes fall through here untouched, the flags have no write path
	always_comb begin
		next_pend = irq_pend & ~pend_rd_clr; // [RULE_08] [RULE_12]
		if (wr && addr == ADDR_IRQ_PEND) begin
			next_pend = next_pend & ~wdata[23:0];
		end
		next_pend = next_pend | pend_set;
		next_mask = irq_mask;
		if (wr && addr == ADDR_IRQ_MASK) begin
			next_mask = wdata[23:0];
		end
		// computed from next values so irq has no extra cycle of lag
		next_irq = |(next_pend & next_mask);
	end

	// bus and interrupt registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_pend <= RST_IRQ;
			irq_mask <= RST_IRQ;
			irq <= 1'b0;
			rdata <= RST_RDATA;
		end else if (ce) begin
			irq_pend <= next_pend;
			irq_mask <= next_mask;
			irq <= next_irq;
			rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// ---- tcv_pkg.sv ----
// shared constants for the timer channel register view
package tcv_pkg;

	// channel count and address layout
	localparam int TCV_NCH = 3;
	localparam int TCV_AW = 8;
	localparam logic [TCV_AW-1:0] TCV_CH_STRIDE = 8'h40;

	// per-channel word offsets inside one 0x40 slot
	localparam logic [5:0] OFS_LIVE = 6'h10;
	localparam logic [5:0] OFS_CAP_A = 6'h14;
	localparam logic [5:0] OFS_CAP_B = 6'h18;
	localparam logic [5:0] OFS_CMP_C = 6'h1C;
	localparam logic [5:0] OFS_STATUS = 6'h20;

	// block-level interrupt registers, above the channel slots
	localparam logic [TCV_AW-1:0] ADDR_IRQ_PEND = 8'hD0;
	localparam logic [TCV_AW-1:0] ADDR_IRQ_MASK = 8'hD4;

	// status word bit positions
	localparam int SB_OUT_B_MIR = 18;
	localparam int SB_OUT_A_MIR = 17;
	localparam int SB_CLK_EN = 16;
	localparam int SB_EXT_TRIG = 7;
	localparam int SB_B_LOAD = 6;
	localparam int SB_A_LOAD = 5;
	localparam int SB_C_CMP = 4;
	localparam int SB_B_CMP = 3;
	localparam int SB_A_CMP = 2;
	localparam int SB_LOAD_OVR = 1;
	localparam int SB_CNT_OVF = 0;
	localparam int TCV_NFLAG = 8;

	// values after reset
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [TCV_NFLAG-1:0] RST_FLAGS = 8'h00;
	localparam logic [23:0] RST_IRQ = 24'h000000;
	localparam logic [31:0] RST_RDATA = 32'h00000000;

endpackage

// ---- tcv_chan.sv ----
`timescale 1ns/1ps
`default_nettype none

// one channel: capture/compare registers, event flags, overrun tracking
module tcv_chan
	import tcv_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic wave, // 1 waveform mode, 0 capture mode
	input wire logic wr_a, // software write of register a
	input wire logic wr_b, // software write of register b
	input wire logic wr_c, // software write of register c
	input wire logic rd_a, // software read of register a
	input wire logic rd_b, // software read of register b
	input wire logic rd_sr, // software read of status
	input wire logic [15:0] wdata, // write data, low half
	input wire logic [15:0] cap_val, // value captured by the engine
	input wire logic ev_ovf, // counter overflow pulse
	input wire logic ev_cmp_a, // register a compare pulse
	input wire logic ev_cmp_b, // register b compare pulse
	input wire logic ev_cmp_c, // register c compare pulse
	input wire logic ev_ld_a, // register a load pulse
	input wire logic ev_ld_b, // register b load pulse
	input wire logic ev_trig, // external trigger pulse
	output logic [15:0] capture_reg_a, // register a content
	output logic [15:0] capture_reg_b, // register b content
	output logic [15:0] period_compare_reg_c, // register c content
	output logic [TCV_NFLAG-1:0] flags, // sticky event flags
	output logic [TCV_NFLAG-1:0] ev_set // events raised this cycle
);

	logic [15:0] next_a;
	logic [15:0] next_b;
	logic [15:0] next_c;
	logic [TCV_NFLAG-1:0] next_flags;
	logic unread_a;
	logic unread_b;
	logic next_unread_a;
	logic next_unread_b;
	logic ld_a;
	logic ld_b;

	// loads count only in capture mode
	assign ld_a = ev_ld_a & ~wave; // [RULE_10]
	assign ld_b = ev_ld_b & ~wave; // [RULE_10]

	// event qualification per mode
	always_comb begin
		ev_set = '0;
		ev_set[SB_EXT_TRIG] = ev_trig;
		ev_set[SB_B_LOAD] = ld_b; // [RULE_10]
		ev_set[SB_A_LOAD] = ld_a; // [RULE_10]
		ev_set[SB_C_CMP] = ev_cmp_c;
		ev_set[SB_B_CMP] = ev_cmp_b & wave; // [RULE_10]
		ev_set[SB_A_CMP] = ev_cmp_a & wave; // [RULE_10]
		// a read in the same cycle takes the old value, so no overrun then
		ev_set[SB_LOAD_OVR] = (ld_a & unread_a & ~rd_a) | (ld_b & unread_b & ~rd_b); // [RULE_09]
		ev_set[SB_CNT_OVF] = ev_ovf;
	end

	// register and flag next values; set beats a clearing read
	always_comb begin
		next_a = capture_reg_a;
		next_b = capture_reg_b;
		next_c = period_compare_reg_c;
		if (ld_a) begin
			next_a = cap_val;
		end else if (wr_a && wave) begin // [RULE_02] [RULE_12]
			next_a = wdata; // [RULE_03]
		end
		if (ld_b) begin
			next_b = cap_val;
		end else if (wr_b && wave) begin // [RULE_02] [RULE_12]
			next_b = wdata; // [RULE_04]
		end
		if (wr_c) begin
			next_c = wdata; // [RULE_05]
		end
		next_unread_a = ld_a | (unread_a & ~rd_a); // [RULE_09]
		next_unread_b = ld_b | (unread_b & ~rd_b); // [RULE_09]
		next_flags = (rd_sr ? RST_FLAGS : flags) | ev_set; // [RULE_08]
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			capture_reg_a <= RST_REG16;
			capture_reg_b <= RST_REG16;
			period_compare_reg_c <= RST_REG16; // [RULE_05]
			flags <= RST_FLAGS;
			unread_a <= 1'b0;
			unread_b <= 1'b0;
		end else if (ce) begin
			capture_reg_a <= next_a;
			capture_reg_b <= next_b;
			period_compare_reg_c <= next_c;
			flags <= next_flags;
			unread_a <= next_unread_a;
			unread_b <= next_unread_b;
		end
	end

endmodule

`default_nettype wire

// ---- tcv_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// channel 0 watcher on the register port of the top level
module tcv_monitor
	import tcv_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic ce, // clock enable
	input wire logic [TCV_AW-1:0] addr, // byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [31:0] rdata, // read data
	input wire logic [TCV_NCH-1:0] wave, // mode
	input wire logic [TCV_NCH-1:0] clk_on, // clock enabled
	input wire logic [TCV_NCH*16-1:0] live_count, // counters
	input wire logic [TCV_NCH-1:0] ev_ovf, // overflow pulses
	input wire logic [TCV_NCH-1:0] ev_ld_a, // a load pulses
	input wire logic [TCV_NCH-1:0] drive_a, // driven a levels
	input wire logic [TCV_NCH*16-1:0] reg_a_out, // register a
	input wire logic [TCV_NCH*16-1:0] reg_b_out, // register b
	input wire logic [TCV_NCH*16-1:0] reg_c_out // register c
);
	logic sr_hit;
	// status read of channel 0 taken this cycle
	assign sr_hit = ce && rd && addr == 8'h20;
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// a load in capture mode without a read of register a beside it
	sequence ld_a_cap;
		ce && ev_ld_a[0] && !wave[0] && !(rd && addr == 8'h14);
	endsequence
	chk_live_read: assert property (ce && rd && addr == 8'h10
		|=> rdata == {16'h0000, $past(live_count[15:0])}) else $error("live count read wrong");
	chk_wave_write: assert property (ce && wr && addr == 8'h14 && wave[0]
		|=> reg_a_out[15:0] == $past(wdata[15:0])) else $error("register a write lost");
	chk_ra_read: assert property (ce && rd && addr == 8'h14
		|=> rdata == {16'h0000, $past(reg_a_out[15:0])}) else $error("register a read wrong");
	chk_rb_read: assert property (ce && rd && addr == 8'h18
		|=> rdata == {16'h0000, $past(reg_b_out[15:0])}) else $error("register b read wrong");
	chk_rc_write: assert property (ce && wr && addr == 8'h1C
		|=> reg_c_out[15:0] == $past(wdata[15:0])) else $error("register c write lost");
	chk_status_hi: assert property (sr_hit |=> rdata[SB_CLK_EN] == $past(clk_on[0])
		&& rdata[31:19] == 13'h0 && rdata[15:8] == 8'h00) else $error("status upper bits wrong");
	chk_load_flag: assert property (ld_a_cap ##1 !rd ##1 sr_hit
		|=> rdata[SB_A_LOAD]) else $error("a load flag missing");
	chk_overrun: assert property (ld_a_cap ##1 !rd ##1 ld_a_cap ##1 !rd ##1 sr_hit
		|=> rdata[SB_LOAD_OVR]) else $error("overrun flag missing");
	chk_sr_clear: assert property (sr_hit && !ev_ovf[0] ##1 !ev_ovf[0] && !rd ##1 sr_hit
		|=> !rdata[SB_CNT_OVF]) else $error("status not cleared by read");
	chk_cap_lock: assert property (ce && wr && addr == 8'h14 && !wave[0] && !ev_ld_a[0]
		|=> $stable(reg_a_out[15:0])) else $error("capture register written");
	chk_wave_mirror: assert property (sr_hit && wave[0]
		|=> rdata[SB_OUT_A_MIR] == $past(drive_a[0])) else $error("a mirror wrong");
endmodule

bind tcv_top tcv_monitor tcv_monitor_i (.ref_clk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata,
	.wave, .clk_on, .live_count, .ev_ovf, .ev_ld_a, .drive_a, .reg_a_out, .reg_b_out, .reg_c_out);

`default_nettype wire

// ---- tcv_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module tcv_top_test;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] wave = 3'h0;
	logic [2:0] clk_on = 3'h1;
	logic [47:0] live_count = 48'h7E013C021F03;
	logic [47:0] cap_val = 48'h0;
	logic [2:0] ev [8] = '{default: 3'h0};
	logic [2:0] io_a = 3'h0;
	logic [2:0] io_b = 3'h1;
	logic [2:0] drive_a = 3'h0;
	logic [2:0] drive_b = 3'h0;
	logic [31:0] rdata;
	logic irq;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;

	// ev index follows the status bit of each event; index 1 unused
	tcv_top tcv_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wave(wave), .clk_on(clk_on),
		.live_count(live_count), .cap_val(cap_val), .ev_ovf(ev[0]), .ev_cmp_a(ev[2]),
		.ev_cmp_b(ev[3]), .ev_cmp_c(ev[4]), .ev_ld_a(ev[5]), .ev_ld_b(ev[6]), .ev_trig(ev[7]),
		.channel_io_a(io_a), .channel_io_b(io_b), .drive_a(drive_a), .drive_b(drive_b),
		.reg_a_out(), .reg_b_out(), .reg_c_out());

	always #10 ref_clk = ~ref_clk;

	// hang guard, far above the hundred or so cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// rdata stands only in the cycle after the strobe, so look there
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("rdata at %h", a), exp, rdata);
	endtask

	// one-cycle event on channel c, with the capture value set beside it
	task automatic pulse(input int k, input int c, input logic [15:0] v);
		@(posedge ref_clk);
		cap_val[c*16+:16] <= v;
		ev[k][c] <= 1'b1;
		@(posedge ref_clk);
		ev[k][c] <= 1'b0;
	endtask

	// one extra edge so a registered irq has settled
	task automatic irq_chk(input logic exp);
		@(posedge ref_clk);
		#1;
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	// reset values, register c, live count, unmapped and read-only places
	task automatic t_regs();
		rd_chk(8'h1C, 32'h00000000);
		wr32(8'h5C, 32'hFFFFA5C3);
		rd_chk(8'h5C, 32'h0000A5C3);
		rd_chk(8'h1C, 32'h00000000);
		rd_chk(8'h90, 32'h00007E01);
		rd_chk(8'h10, 32'h00001F03);
		rd_chk(8'h30, 32'h00000000);
		wr32(8'h60, 32'h000700FF);
		rd_chk(8'h60, 32'h00000000);
	endtask

	// capture mode: writes refused, loads, overrun, flag layout, read-to-clear
	task automatic t_cap();
		wr32(8'h14, 32'h00001234);
		rd_chk(8'h14, 32'h00000000);
		pulse(5, 0, 16'h1111);
		pulse(5, 0, 16'h2222);
		rd_chk(8'h20, 32'h00050022);
		rd_chk(8'h14, 32'h00002222);
		pulse(0, 0, 16'h2222);
		pulse(7, 0, 16'h2222);
		pulse(4, 0, 16'h2222);
		pulse(2, 0, 16'h2222);
		pulse(6, 0, 16'h0BBB);
		rd_chk(8'h20, 32'h000500D1);
		rd_chk(8'h20, 32'h00050000);
		rd_chk(8'h18, 32'h00000BBB);
	endtask

	// waveform mode: a and b writable, compares kept, loads ignored, driven mirror
	task automatic t_wave();
		@(posedge ref_clk);
		wave <= 3'h1;
		drive_a <= 3'h1;
		wr32(8'h14, 32'hFFFF4321);
		wr32(8'h18, 32'h0000BEEF);
		rd_chk(8'h14, 32'h00004321);
		pulse(2, 0, 16'h5555);
		pulse(3, 0, 16'h5555);
		pulse(6, 0, 16'h5555);
		rd_chk(8'h20, 32'h0003000C);
		rd_chk(8'h18, 32'h0000BEEF);
	endtask

	// masked and unmasked events, write-one clear, status read clears pending
	task automatic t_irq();
		wr32(8'hD4, 32'h00000001);
		pulse(0, 1, 16'h0000);
		irq_chk(1'b0);
		pulse(0, 0, 16'h0000);
		irq_chk(1'b1);
		wr32(8'hD0, 32'h00000001);
		irq_chk(1'b0);
		rd_chk(8'hD0, 32'h00000100);
		wr32(8'hD4, 32'h00000100);
		irq_chk(1'b1);
		rd_chk(8'h60, 32'h00000001);
		irq_chk(1'b0);
		rd_chk(8'hD0, 32'h00000000);
	endtask

	// clock enable low drops a write; the same write lands once enabled
	task automatic t_ce();
		@(posedge ref_clk);
		ce <= 1'b0;
		wr32(8'h1C, 32'h0000C33C);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd_chk(8'h1C, 32'h00000000);
		wr32(8'h1C, 32'h0000C33C);
		rd_chk(8'h1C, 32'h0000C33C);
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_ce();
		t_cap();
		t_wave();
		t_irq();
		close_out();
	end
endmodule

`default_nettype wire
